// ==== test/ddr_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddr_source_model
  import parity_alarm_pkg::*;
(
  input  wire logic                          i_run,
  input  wire parity_alarm_pkg::check_mode_t i_mode,
  input  wire logic [3:0]                    i_bad,
  input  wire logic [31:0]                   i_rand,
  output logic                               o_data_clk,
  output parity_alarm_pkg::ddr_word_t        o_word
);
  // One word; e1 and e2 spoil the parity of the first and second path
  function automatic ddr_word_t mk(input logic [31:0] r,
                                   input logic        e1,
                                   input logic        e2);
    ddr_word_t w;
    w.ab = r[31:16];
    w.cd = r[15:0];
    w.strobe = i_mode.split_en ? (^w.ab ^ i_mode.odd_sense ^ e1) : r[3];
    w.check = i_mode.split_en ? (^w.cd ^ i_mode.odd_sense ^ e2)
                              : (^r ^ i_mode.odd_sense ^ e1);
    return w;
  endfunction
  // Data moves mid-phase, far from either clock edge
  initial
  begin
    o_data_clk = 1'b0;
    o_word = '0;
    #1.3;
    forever
    begin
      #31.25 o_word = mk(i_rand, i_bad[0], i_bad[2]);
      #31.25 o_data_clk = i_run;
      #31.25 o_word = mk(i_rand, i_bad[1], i_bad[3]);
      #31.25 o_data_clk = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== test/input_parity_alarm_monitor_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "parity_alarm_consts.svh"
module input_parity_alarm_monitor_sva (
  input wire logic        i_mclk,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        i_data_clk,
  input wire logic        i_ptr_equal,
  input wire logic        i_conv_clk_gone,
  input wire logic        i_pll_unlocked,
  input wire logic        i_pattern_mismatch,
  input wire logic        o_fault,
  input wire logic        o_output_off,
  input wire logic        o_strobe_ptr_sync
);
  logic [12:0] mask_q;
  logic [1:0]  shut_q;
  logic        split_q;
  logic        clk_d;
  logic [7:0]  idle_q;
  logic        wr;
  assign wr = i_psel && i_penable && i_pwrite && o_pready;
  // Shadow of control writes, rebuilt from bus traffic only
  always_ff @(posedge i_mclk or posedge i_rst)
    if (i_rst)
    begin
      mask_q  <= 13'h1FFF;
      shut_q  <= 2'h0;
      split_q <= 1'b0;
      clk_d   <= 1'b0;
      idle_q  <= 8'h00;
    end
    else
    begin
      if (wr && i_paddr == `OFS_FAULT_MASK) mask_q <= i_pwdata[12:0];
      if (wr && i_paddr == `OFS_SHUTOFF_CONTROL) shut_q <= i_pwdata[1:0];
      if (wr && i_paddr == `OFS_CHECK_CONTROL)
        split_q <= i_pwdata[`BIT_SPLIT_EN];
      clk_d  <= i_data_clk;
      // Saturates so a long stall never wraps back to zero
      idle_q <= (i_data_clk != clk_d) ? 8'h00 :
                (idle_q == 8'hFF) ? idle_q : idle_q + 8'h01;
    end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  property p_mask_all;
    mask_q == 13'h1FFF && $past(mask_q) == 13'h1FFF |-> !o_fault;
  endproperty
  a_mask_all: assert property (p_mask_all) else $error("masked fault");
  property p_pll_set;
    i_pll_unlocked && !mask_q[`BIT_PLL] |-> ##[1:4] o_fault;
  endproperty
  a_pll_set: assert property (p_pll_set) else $error("pll fault late");
  property p_pll_hold;
    (i_pll_unlocked && !mask_q[`BIT_PLL]) [*4] |-> o_fault;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("live fault lost");
  property p_pattern;
    i_pattern_mismatch && !mask_q[`BIT_PATTERN] |-> ##[1:4] o_fault;
  endproperty
  a_pattern: assert property (p_pattern) else $error("pattern late");
  property p_coll_off;
    i_ptr_equal && shut_q[1] |-> ##[1:4] o_output_off;
  endproperty
  a_coll_off: assert property (p_coll_off) else $error("no shutoff");
  property p_conv_off;
    i_conv_clk_gone && shut_q[0] |-> ##[1:4] o_output_off;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("no shutoff");
  property p_no_shut;
    shut_q == 2'h0 && $past(shut_q) == 2'h0 |-> !o_output_off;
  endproperty
  a_no_shut: assert property (p_no_shut) else $error("stray shutoff");
  property p_split_nosync;
    split_q && $past(split_q, 3) |-> !o_strobe_ptr_sync;
  endproperty
  a_split_nosync: assert property (p_split_nosync) else $error("sync");
  property p_clk_gone;
    idle_q == 8'hE6 && !mask_q[`BIT_DATA_CLK_GONE] |-> o_fault;
  endproperty
  a_clk_gone: assert property (p_clk_gone) else $error("clk gone");
  c_fault: cover property ($rose(o_fault));
  c_off: cover property ($rose(o_output_off));
  c_sync: cover property (o_strobe_ptr_sync);
endmodule
bind input_parity_alarm_monitor input_parity_alarm_monitor_sva i_sva (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .i_data_clk(i_data_clk),
  .i_ptr_equal(i_ptr_equal), .i_conv_clk_gone(i_conv_clk_gone),
  .i_pll_unlocked(i_pll_unlocked), .i_pattern_mismatch(i_pattern_mismatch),
  .o_fault(o_fault), .o_output_off(o_output_off),
  .o_strobe_ptr_sync(o_strobe_ptr_sync)
);
`default_nettype wire

// ==== test/test_input_parity_alarm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "parity_alarm_consts.svh"
module test_input_parity_alarm_monitor;
  import parity_alarm_pkg::*;
  logic        mclk, rst, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        pready, pslverr, dclk, run, fault, out_off, ptr_sync;
  logic [6:0]  flt;
  logic [3:0]  bad;
  check_mode_t mode;
  ddr_word_t   link;
  logic [32:0] exp_q[$];
  int          err_total, total_checks, syncs;
  logic [2:0]  modes [5] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
  logic [31:0] fexp [7] = '{32'h1000, 32'h0C00, 32'h0A00, 32'h0900,
                            32'h0080, 32'h0020, 32'h0010};
  input_parity_alarm_monitor i_dut (
    .i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata),
    .i_data_clk(dclk), .i_link(link), .i_ptr_zero(flt[0]),
    .i_ptr_two_apart(flt[1]), .i_ptr_one_apart(flt[2]),
    .i_ptr_equal(flt[3]), .i_conv_clk_gone(flt[4]),
    .i_pll_unlocked(flt[5]), .i_pattern_mismatch(flt[6]),
    .o_fault(fault), .o_output_off(out_off), .o_strobe_ptr_sync(ptr_sync));
  ddr_source_model i_src (.i_run(run), .i_mode(mode), .i_bad(bad),
    .i_rand(rnd), .o_data_clk(dclk), .o_word(link));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
  endfunction
  task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    total_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] e);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back(e);
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask
  task wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task set_mode(input logic [2:0] m);
    mode <= '{m[0], m[1], m[2]};
    wr(`OFS_CHECK_CONTROL, {29'h0, m});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) rnd <= lfsr(rnd);
  always @(posedge mclk) if (ptr_sync === 1'b1) syncs++;
  // Read answers are judged where they appear on the bus
  always @(posedge mclk)
    if (psel && penable && !pwrite && pready === 1'b1)
      chk("prdata", {pslverr, prdata}, exp_q.pop_front());
  initial
  begin
    #200us;
    err_total++;
    tally_and_finish();
  end
  initial
  begin
    {rst, run} = 2'h3;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {flt, bad, mode} = '0;
    rnd = 32'h00000038;
    {err_total, total_checks, syncs} = '0;
    wt(16);
    rst <= 1'b0;
    rd(`OFS_CHECK_CONTROL, 32'h0);
    rd(`OFS_SHUTOFF_CONTROL, 32'h0);
    rd(`OFS_FAULT_STATUS, 32'h0);
    rd(`OFS_FAULT_MASK, 32'h1FFF);
    rd(`OFS_SYNC_SELECT, 32'h0);
    apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
    $display("test reset done");
    for (int m = 0; m < 5; m++)
    begin
      set_mode(modes[m]);
      for (int k = 0; k < 4; k++)
      begin
        if (k > 1 && !modes[m][1]) continue;
        wt(60);
        wr(`OFS_FAULT_STATUS, 32'h0);
        bad <= 4'h1 << k;
        wt(30);
        bad <= 4'h0;
        wt(30);
        rd(`OFS_FAULT_STATUS, 32'h1 << k);
        chk("fault", fault, 1'b0);
      end
    end
    $display("test parity done");
    set_mode(3'h4);
    bad <= 4'hF;
    wr(`OFS_FAULT_MASK, 32'h0);
    wr(`OFS_SHUTOFF_CONTROL, 32'h3);
    wt(20);
    wr(`OFS_FAULT_STATUS, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      flt <= 7'h1 << i;
      wt(4);
      wr(`OFS_FAULT_STATUS, 32'h0);
      rd(`OFS_FAULT_STATUS, fexp[i]);
      chk("off", out_off, (i == 3 || i == 4));
      chk("fault", fault, 1'b1);
      flt <= 7'h0;
      wt(2);
      wr(`OFS_FAULT_STATUS, 32'h0);
      wt(3);
      rd(`OFS_FAULT_STATUS, 32'h0);
      chk("fault", fault, 1'b0);
    end
    $display("test faults done");
    run <= 1'b0;
    wt(300);
    rd(`OFS_FAULT_STATUS, 32'h0040);
    chk("off", out_off, 1'b1);
    run <= 1'b1;
    wt(30);
    wr(`OFS_FAULT_STATUS, 32'h0);
    wt(3);
    rd(`OFS_FAULT_STATUS, 32'h0);
    $display("test clock gone done");
    bad <= 4'h0;
    wr(`OFS_SYNC_SELECT, 32'h1);
    wt(10);
    syncs = 0;
    wt(200);
    chk("sync", syncs != 0, 1'b1);
    set_mode(3'h6);
    wt(10);
    syncs = 0;
    wt(200);
    chk("sync", syncs != 0, 1'b0);
    $display("test strobe sync done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ==== verilog/ddr_link_sampler.sv ====
`timescale 1ns/1ps
`default_nettype none
module ddr_link_sampler
  import parity_alarm_pkg::*;
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic                        i_data_clk,
  input  wire parity_alarm_pkg::ddr_word_t i_pins,
  output logic                             o_word_valid,
  output logic                             o_word_fall,
  output parity_alarm_pkg::ddr_word_t      o_word,
  output logic                             o_clk_edge,
  output logic                             o_strobe_rise
);

  localparam int W = $bits(ddr_word_t) + 1;

  logic [W-1:0] sync1;
  logic [W-1:0] sync2;
  logic [W-1:0] sync3;
  logic         clk_level;
  logic         strobe_level;
  logic         next_clk_level;
  logic         next_strobe_level;
  logic         next_valid;
  logic         next_fall;
  logic         next_strobe_rise;
  ddr_word_t    next_word;

  ////////////////////////////////////////////////////////////////////////////
  // Edge finding: a change counts when stages two and three agree
  always_comb
  begin
    next_clk_level    = clk_level;
    next_strobe_level = strobe_level;
    next_valid        = 1'b0;
    next_fall         = o_word_fall;
    next_word         = o_word;
    next_strobe_rise  = 1'b0;
    if ((sync2[W-1] == sync3[W-1]) && (sync3[W-1] != clk_level))
    begin
      next_clk_level = sync3[W-1];
      next_valid     = 1'b1;
      next_fall      = ~sync3[W-1];
      // Data sampled mid-bit; source holds it across the data clock edge
      next_word      = sync3[W-2:0];
    end
    if ((sync2[1] == sync3[1]) && (sync3[1] != strobe_level))
    begin
      next_strobe_level = sync3[1];
      next_strobe_rise  = sync3[1];
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      sync1         <= '0;
      sync2         <= '0;
      sync3         <= '0;
      clk_level     <= 1'b0;
      strobe_level  <= 1'b0;
      o_word_valid  <= 1'b0;
      o_word_fall   <= 1'b0;
      o_word        <= '0;
      o_strobe_rise <= 1'b0;
    end
    else
    begin
      sync1         <= {i_data_clk, i_pins};
      sync2         <= sync1;
      sync3         <= sync2;
      clk_level     <= next_clk_level;
      strobe_level  <= next_strobe_level;
      o_word_valid  <= next_valid;
      o_word_fall   <= next_fall;
      o_word        <= next_word;
      o_strobe_rise <= next_strobe_rise;
    end
  end

  assign o_clk_edge = o_word_valid;

endmodule
`default_nettype wire

// ==== verilog/input_parity_alarm_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "parity_alarm_consts.svh"
module input_parity_alarm_monitor
  import parity_alarm_pkg::*;
(
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  // APB slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [7:0]                  i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  output logic [31:0]                      o_prdata,
  // Sample link
  input  wire logic                        i_data_clk,
  input  wire parity_alarm_pkg::ddr_word_t i_link,
  // Fault sources from neighbouring logic on i_mclk
  input  wire logic                        i_ptr_zero,
  input  wire logic                        i_ptr_two_apart,
  input  wire logic                        i_ptr_one_apart,
  input  wire logic                        i_ptr_equal,
  input  wire logic                        i_conv_clk_gone,
  input  wire logic                        i_pll_unlocked,
  input  wire logic                        i_pattern_mismatch,
  // Results
  output logic                             o_fault,
  output logic                             o_output_off,
  output logic                             o_strobe_ptr_sync
);

  localparam logic [7:0] GONE_CYC = 8'(`DATA_CLK_GONE_CYC);

  // Watchdog counter is eight bits; refuse a timeout it cannot reach
  if ((`DATA_CLK_GONE_CYC < 1) || (`DATA_CLK_GONE_CYC > 255))
  begin : g_gone_check
    $error("data clock timeout does not fit its counter");
  end

  check_mode_t                 mode;
  logic [1:0]                  shutoff_ctl;
  logic [`FAULT_BITS-1:0]      status;
  logic [`FAULT_BITS-1:0]      mask;
  logic                        strobe_sync_sel;
  logic [7:0]                  gone_cnt;
  logic                        data_clk_gone;
  logic                        output_off;
  logic                        strobe_sync;
  logic [31:0]                 rdata;
  logic                        slverr;

  check_mode_t                 next_mode;
  logic [1:0]                  next_shutoff_ctl;
  logic [`FAULT_BITS-1:0]      next_status;
  logic [`FAULT_BITS-1:0]      next_mask;
  logic                        next_strobe_sync_sel;
  logic [7:0]                  next_gone_cnt;
  logic                        next_data_clk_gone;
  logic                        next_output_off;
  logic                        next_strobe_sync;
  logic [31:0]                 next_rdata;
  logic                        next_slverr;

  logic                        word_valid;
  logic                        word_fall;
  ddr_word_t                   word;
  logic                        clk_edge;
  logic                        strobe_rise;
  logic [3:0]                  par_err;
  logic [`FAULT_BITS-1:0]      events;
  logic                        setup;
  logic                        wr_access;

  // Address decode shared by read and write paths
  function automatic logic [2:0] decode(input logic [7:0] addr);
    case (addr)
      `OFS_CHECK_CONTROL:   decode = 3'h1;
      `OFS_SHUTOFF_CONTROL: decode = 3'h2;
      `OFS_FAULT_STATUS:    decode = 3'h3;
      `OFS_FAULT_MASK:      decode = 3'h4;
      `OFS_SYNC_SELECT:     decode = 3'h5;
      default:              decode = 3'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link capture and parity
  ddr_link_sampler u_sampler
  (
    .i_mclk        (i_mclk),
    .i_rst         (i_rst),
    .i_data_clk    (i_data_clk),
    .i_pins        (i_link),
    .o_word_valid  (word_valid),
    .o_word_fall   (word_fall),
    .o_word        (word),
    .o_clk_edge    (clk_edge),
    .o_strobe_rise (strobe_rise)
  );

  parity_judge u_judge
  (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_mode       (mode),
    .i_word_valid (word_valid),
    .i_word_fall  (word_fall),
    .i_word       (word),
    .o_err        (par_err)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault event collection
  always_comb
  begin
    events                     = '0;
    events[`BIT_PAR_A]         = par_err[0];
    events[`BIT_PAR_B]         = par_err[1];
    events[`BIT_PAR_C]         = par_err[2];
    events[`BIT_PAR_D]         = par_err[3];
    events[`BIT_PATTERN]       = i_pattern_mismatch;
    events[`BIT_PLL]           = i_pll_unlocked;
    events[`BIT_DATA_CLK_GONE] = data_clk_gone;
    events[`BIT_CONV_CLK_GONE] = i_conv_clk_gone;
    events[`BIT_COLLISION]     = i_ptr_equal;
    events[`BIT_ONE_APART]     = i_ptr_one_apart;
    events[`BIT_TWO_APART]     = i_ptr_two_apart;
    events[`BIT_FIFO_SUMMARY]  = i_ptr_equal | i_ptr_one_apart
                               | i_ptr_two_apart;
    events[`BIT_ZERO_PTR]      = i_ptr_zero;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data clock watchdog
  always_comb
  begin
    next_gone_cnt      = gone_cnt;
    next_data_clk_gone = data_clk_gone;
    if (clk_edge)
    begin
      next_gone_cnt      = 8'h00;
      next_data_clk_gone = 1'b0;
    end
    else if (gone_cnt >= GONE_CYC)
      next_data_clk_gone = 1'b1;
    else
      next_gone_cnt = gone_cnt + 8'h01;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gone_cnt      <= 8'h00;
      data_clk_gone <= 1'b0;
    end
    else
    begin
      gone_cnt      <= next_gone_cnt;
      data_clk_gone <= next_data_clk_gone;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  assign setup     = i_psel & ~i_penable;
  assign wr_access = i_psel & i_penable & i_pwrite;

  always_comb
  begin
    next_mode            = mode;
    next_shutoff_ctl     = shutoff_ctl;
    next_mask            = mask;
    next_strobe_sync_sel = strobe_sync_sel;
    next_status          = status;
    next_rdata           = rdata;
    next_slverr          = slverr;
    if (setup)
    begin
      next_slverr = (decode(i_paddr) == 3'h0);
      next_rdata  = 32'h0000_0000;
      unique case (decode(i_paddr))
        3'h1: next_rdata[2:0] = {mode.odd_sense, mode.split_en,
                                 mode.wide_en};
        3'h2: next_rdata[1:0] = shutoff_ctl;
        3'h3: next_rdata[`FAULT_BITS-1:0] = status;
        3'h4: next_rdata[`FAULT_BITS-1:0] = mask;
        3'h5: next_rdata[0] = strobe_sync_sel;
        3'h0: next_rdata = 32'h0000_0000;
      endcase
    end
    if (wr_access)
    begin
      unique case (decode(i_paddr))
        3'h1:
        begin
          next_mode.wide_en   = i_pwdata[`BIT_WIDE_EN];
          next_mode.split_en  = i_pwdata[`BIT_SPLIT_EN];
          next_mode.odd_sense = i_pwdata[`BIT_ODD_SENSE];
        end
        3'h2: next_shutoff_ctl = i_pwdata[1:0];
        // Writing zero clears, writing one leaves the bit alone
        3'h3: next_status = status & i_pwdata[`FAULT_BITS-1:0];
        3'h4: next_mask = i_pwdata[`FAULT_BITS-1:0];
        3'h5: next_strobe_sync_sel = i_pwdata[`BIT_STROBE_SYNC];
        3'h0: next_status = status;
      endcase
    end
    // Set after clear: a live fault survives a clearing write
    next_status = next_status | events;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode            <= check_mode_t'(`RST_CHECK_CONTROL);
      shutoff_ctl     <= `RST_SHUTOFF_CONTROL;
      status          <= `RST_FAULT_STATUS;
      mask            <= `RST_FAULT_MASK;
      strobe_sync_sel <= `RST_SYNC_SELECT;
      rdata           <= 32'h0000_0000;
      slverr          <= 1'b0;
    end
    else
    begin
      mode            <= next_mode;
      shutoff_ctl     <= next_shutoff_ctl;
      status          <= next_status;
      mask            <= next_mask;
      strobe_sync_sel <= next_strobe_sync_sel;
      rdata           <= next_rdata;
      slverr          <= next_slverr;
    end
  end

  // Zero wait states; read data was latched in the setup cycle
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & slverr;
  assign o_prdata  = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Fault pin, output shutoff, strobe pointer sync
  always_comb
  begin
    // Sticky status drives shutoff so outputs stay off until cleared
    next_output_off =
      (shutoff_ctl[`BIT_SHUT_CLK_GONE] &
       (status[`BIT_DATA_CLK_GONE] | status[`BIT_CONV_CLK_GONE])) |
      (shutoff_ctl[`BIT_SHUT_COLLISION] & status[`BIT_COLLISION]);
    // Strobe carries parity in split mode, so it may not move pointers
    next_strobe_sync = strobe_rise & strobe_sync_sel
                     & ~mode.split_en;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      output_off  <= 1'b0;
      strobe_sync <= 1'b0;
      o_fault     <= 1'b0;
    end
    else
    begin
      output_off  <= next_output_off;
      strobe_sync <= next_strobe_sync;
      o_fault     <= |(status & ~mask);
    end
  end

  assign o_output_off      = output_off;
  assign o_strobe_ptr_sync = strobe_sync;

endmodule
`default_nettype wire

// ==== verilog/parity_alarm_consts.svh ====
`ifndef PARITY_ALARM_CONSTS_SVH
`define PARITY_ALARM_CONSTS_SVH

// Register byte offsets
`define OFS_CHECK_CONTROL   8'h00
`define OFS_SHUTOFF_CONTROL 8'h04
`define OFS_FAULT_STATUS    8'h08
`define OFS_FAULT_MASK      8'h0C
`define OFS_SYNC_SELECT     8'h10

// check_control_reg fields
`define BIT_WIDE_EN         0
`define BIT_SPLIT_EN        1
`define BIT_ODD_SENSE       2

// shutoff_control_reg fields
`define BIT_SHUT_CLK_GONE   0
`define BIT_SHUT_COLLISION  1

// sync_select_reg fields
`define BIT_STROBE_SYNC     0

// fault_status_reg fields
`define BIT_PAR_A           0
`define BIT_PAR_B           1
`define BIT_PAR_C           2
`define BIT_PAR_D           3
`define BIT_PATTERN         4
`define BIT_PLL             5
`define BIT_DATA_CLK_GONE   6
`define BIT_CONV_CLK_GONE   7
`define BIT_COLLISION       8
`define BIT_ONE_APART       9
`define BIT_TWO_APART       10
`define BIT_FIFO_SUMMARY    11
`define BIT_ZERO_PTR        12
`define FAULT_BITS          13

// Reset values
`define RST_CHECK_CONTROL   3'h0
`define RST_SHUTOFF_CONTROL 2'h0
`define RST_FAULT_STATUS    13'h0000
`define RST_FAULT_MASK      13'h1FFF
`define RST_SYNC_SELECT     1'h0

// Timing
`define MCLK_PERIOD_PS      5000
`define DATA_CLK_GONE_NS    1000
`define DATA_CLK_GONE_CYC   ((`DATA_CLK_GONE_NS * 1000) / `MCLK_PERIOD_PS)

`endif

// ==== verilog/parity_alarm_pkg.sv ====
`default_nettype none
package parity_alarm_pkg;

  typedef struct packed {
    logic [15:0] ab;
    logic [15:0] cd;
    logic        strobe;
    logic        check;
  } ddr_word_t;

  typedef struct packed {
    logic wide_en;
    logic split_en;
    logic odd_sense;
  } check_mode_t;

endpackage
`default_nettype wire

// ==== verilog/parity_judge.sv ====
`timescale 1ns/1ps
`default_nettype none
module parity_judge
  import parity_alarm_pkg::*;
(
  input  wire logic                          i_mclk,
  input  wire logic                          i_rst,
  input  wire parity_alarm_pkg::check_mode_t i_mode,
  input  wire logic                          i_word_valid,
  input  wire logic                          i_word_fall,
  input  wire parity_alarm_pkg::ddr_word_t   i_word,
  output logic [3:0]                         o_err
);

  logic [3:0] next_err;

  // True when the count of ones disagrees with the selected sense
  function automatic logic wrong(input logic ones_odd, input logic odd_sense);
    wrong = ones_odd ^ odd_sense;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic wide_bad;
    logic path1_bad;
    logic path2_bad;
    wide_bad  = wrong(^{i_word.ab, i_word.cd, i_word.check},
                      i_mode.odd_sense);
    path1_bad = wrong(^{i_word.ab, i_word.strobe}, i_mode.odd_sense);
    path2_bad = wrong(^{i_word.cd, i_word.check}, i_mode.odd_sense);
    next_err  = 4'h0;
    if (i_word_valid)
    begin
      // Split mode wins when software sets both enables
      if (i_mode.split_en)
      begin
        next_err[0] = path1_bad & ~i_word_fall;
        next_err[1] = path1_bad &  i_word_fall;
        next_err[2] = path2_bad & ~i_word_fall;
        next_err[3] = path2_bad &  i_word_fall;
      end
      else if (i_mode.wide_en)
      begin
        next_err[0] = wide_bad & ~i_word_fall;
        next_err[1] = wide_bad &  i_word_fall;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_err <= 4'h0;
    else
      o_err <= next_err;
  end

endmodule
`default_nettype wire
